// ---- rtl/rmp_pkg.sv ----
package rmp_pkg;

  // ****************************************************************
  // Address and boundary layout
  // ****************************************************************
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned GRAN_LSB     = 3;
  localparam int unsigned BND_W        = ADDR_W - GRAN_LSB;
  localparam logic [2:0]  BND_LOW_ZERO = 3'h0;

  // ****************************************************************
  // Documented limits
  // ****************************************************************
  localparam int unsigned RANGES_MIN   = 4;
  localparam int unsigned RANGES_MAX   = 16;
  localparam int unsigned RANGES_DEF   = 16;
  localparam int unsigned SETS_MIN     = 2;
  localparam int unsigned SETS_MAX     = 4;
  localparam int unsigned SETS_DEF     = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [ADDR_W-1:0] BND_RST  = 32'h0000_0000;
  localparam logic              PERM_RST = 1'b0;

  // ****************************************************************
  // Access kind encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    RMP_ACC_LOAD  = 2'b00,
    RMP_ACC_STORE = 2'b01,
    RMP_ACC_FETCH = 2'b10
  } rmp_acc_e;

endpackage

// ---- rtl/rmp_range_match.sv ----
`timescale 1ns/1ns
module rmp_range_match #(
  parameter int unsigned RANGES = rmp_pkg::RANGES_DEF
) (
  // Address under test
  input  wire logic [rmp_pkg::ADDR_W-1:0]        addr,
  // Boundary table, flattened range by range
  input  wire logic [RANGES*rmp_pkg::ADDR_W-1:0] lower,
  input  wire logic [RANGES*rmp_pkg::ADDR_W-1:0] upper,
  // Permission bits of the active set for this kind
  input  wire logic [RANGES-1:0]                 permit,
  // Granted when any permitted range covers the address
  output logic                                   grant
);

  logic [RANGES-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < RANGES; i++) begin : g_rng
      wire logic [rmp_pkg::BND_W-1:0] a_g;
      wire logic [rmp_pkg::BND_W-1:0] lo_g;
      wire logic [rmp_pkg::BND_W-1:0] hi_g;
      // Only the bits above the granule take part in the comparison.
      assign a_g   = addr[rmp_pkg::ADDR_W-1:rmp_pkg::GRAN_LSB];
      assign lo_g  = lower[i*rmp_pkg::ADDR_W+rmp_pkg::GRAN_LSB +: rmp_pkg::BND_W];
      assign hi_g  = upper[i*rmp_pkg::ADDR_W+rmp_pkg::GRAN_LSB +: rmp_pkg::BND_W];
      assign hit[i] = permit[i] && (a_g >= lo_g) && (a_g < hi_g);
    end
  endgenerate

  assign grant = |hit;

endmodule

// ---- rtl/rmp_checker.sv ----
`timescale 1ns/1ns
module rmp_checker #(
  parameter int unsigned CODE_RANGES = rmp_pkg::RANGES_DEF,
  parameter int unsigned DATA_RANGES = rmp_pkg::RANGES_DEF,
  parameter int unsigned SETS        = rmp_pkg::SETS_DEF,
  localparam int unsigned SET_W      = (SETS > 2) ? 2 : 1,
  localparam int unsigned AW         = rmp_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   srst,
  // Control from the processor status and system control registers
  input  wire logic                   guard_enable_bit,
  input  wire logic [SET_W-1:0]       active_set_field,
  // Boundary register write port
  input  wire logic                   bnd_wr,
  input  wire logic                   bnd_code,
  input  wire logic                   bnd_upper,
  input  wire logic [3:0]             bnd_idx,
  input  wire logic [AW-1:0]          bnd_wdata,
  // Boundary register read port
  input  wire logic                   bnd_rd_code,
  input  wire logic                   bnd_rd_upper,
  input  wire logic [3:0]             bnd_rd_idx,
  output logic [AW-1:0]               bnd_rdata,
  // Permission enable register write port
  input  wire logic                   perm_wr,
  input  wire logic [1:0]             perm_kind,
  input  wire logic [SET_W-1:0]       perm_set,
  input  wire logic [15:0]            perm_wdata,
  // Permission enable register read port
  input  wire logic [1:0]             perm_rd_kind,
  input  wire logic [SET_W-1:0]       perm_rd_set,
  output logic [15:0]                 perm_rdata,
  // Access request from the load/store and fetch units
  input  wire logic                   req_valid,
  input  wire logic [1:0]             req_kind,
  input  wire logic [AW-1:0]          req_addr,
  input  wire logic                   req_paged,
  // Verdict towards the memory system and the trap logic
  output logic                        mem_valid,
  output logic [1:0]                  mem_kind,
  output logic [AW-1:0]               mem_addr,
  output logic                        store_violation_trap,
  output logic                        load_violation_trap,
  output logic                        fetch_violation_trap
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  generate
    if (CODE_RANGES < rmp_pkg::RANGES_MIN || CODE_RANGES > rmp_pkg::RANGES_MAX ||
        DATA_RANGES < rmp_pkg::RANGES_MIN || DATA_RANGES > rmp_pkg::RANGES_MAX) begin : g_bad_rng
      $error("Range count must lie between four and sixteen.");
    end
    if (SETS < rmp_pkg::SETS_MIN || SETS > rmp_pkg::SETS_MAX) begin : g_bad_set
      $error("Set count must lie between two and four.");
    end
  endgenerate

  // ****************************************************************
  // Boundary tables
  // ****************************************************************
  logic [CODE_RANGES*AW-1:0] code_lo;
  logic [CODE_RANGES*AW-1:0] code_hi;
  logic [DATA_RANGES*AW-1:0] data_lo;
  logic [DATA_RANGES*AW-1:0] data_hi;

  wire logic [AW-1:0] bnd_wval;
  // The granule bits are forced to zero so they never store a write.
  assign bnd_wval = {bnd_wdata[AW-1:rmp_pkg::GRAN_LSB], rmp_pkg::BND_LOW_ZERO};

  // ****************************************************************
  // Boundary write decode
  // ****************************************************************
  // Each half of each table has its own strobe, so every register
  // process below sees the two strobes of its table and one source.
  wire logic wr_code_lo;
  wire logic wr_code_hi;
  wire logic wr_data_lo;
  wire logic wr_data_hi;
  assign wr_code_lo = bnd_wr && bnd_code && !bnd_upper;
  assign wr_code_hi = bnd_wr && bnd_code && bnd_upper;
  assign wr_data_lo = bnd_wr && !bnd_code && !bnd_upper;
  assign wr_data_hi = bnd_wr && !bnd_code && bnd_upper;

  genvar c;
  generate
    for (c = 0; c < CODE_RANGES; c++) begin : g_code
      wire logic sel_c;
      assign sel_c = (bnd_idx == 4'(c));
      always_ff @(posedge clock) begin
        if (srst) begin
          code_lo[c*AW +: AW] <= rmp_pkg::BND_RST;
          code_hi[c*AW +: AW] <= rmp_pkg::BND_RST;
        end else if (wr_code_hi && sel_c) begin
          code_hi[c*AW +: AW] <= bnd_wval;
        end else if (wr_code_lo && sel_c) begin
          code_lo[c*AW +: AW] <= bnd_wval;
        end
      end
    end
    for (c = 0; c < DATA_RANGES; c++) begin : g_data
      wire logic sel_d;
      assign sel_d = (bnd_idx == 4'(c));
      always_ff @(posedge clock) begin
        if (srst) begin
          data_lo[c*AW +: AW] <= rmp_pkg::BND_RST;
          data_hi[c*AW +: AW] <= rmp_pkg::BND_RST;
        end else if (wr_data_hi && sel_d) begin
          data_hi[c*AW +: AW] <= bnd_wval;
        end else if (wr_data_lo && sel_d) begin
          data_lo[c*AW +: AW] <= bnd_wval;
        end
      end
    end
  endgenerate

  wire logic [AW-1:0] rd_code_w;
  wire logic [AW-1:0] rd_data_w;
  wire logic          rd_code_ok;
  wire logic          rd_data_ok;
  assign rd_code_ok = 32'(bnd_rd_idx) < CODE_RANGES;
  assign rd_data_ok = 32'(bnd_rd_idx) < DATA_RANGES;
  assign rd_code_w  = !rd_code_ok ? '0 : bnd_rd_upper ?
                      code_hi[bnd_rd_idx*AW +: AW] : code_lo[bnd_rd_idx*AW +: AW];
  assign rd_data_w  = !rd_data_ok ? '0 : bnd_rd_upper ?
                      data_hi[bnd_rd_idx*AW +: AW] : data_lo[bnd_rd_idx*AW +: AW];
  assign bnd_rdata  = bnd_rd_code ? rd_code_w : rd_data_w;

  // ****************************************************************
  // Per-set permission enable registers
  // ****************************************************************
  logic [DATA_RANGES-1:0] load_en  [SETS];
  logic [DATA_RANGES-1:0] store_en [SETS];
  logic [CODE_RANGES-1:0] fetch_en [SETS];

  // ****************************************************************
  // Permission write decode
  // ****************************************************************
  // Kind three raises none of these strobes, so such a write is dropped.
  wire logic wr_load;
  wire logic wr_store;
  wire logic wr_fetch;
  assign wr_load  = perm_wr && (perm_kind == rmp_pkg::RMP_ACC_LOAD);
  assign wr_store = perm_wr && (perm_kind == rmp_pkg::RMP_ACC_STORE);
  assign wr_fetch = perm_wr && (perm_kind == rmp_pkg::RMP_ACC_FETCH);

  genvar s;
  generate
    for (s = 0; s < SETS; s++) begin : g_set
      wire logic hit_s;
      assign hit_s = (perm_set == SET_W'(s));
      always_ff @(posedge clock) begin
        if (srst) begin
          load_en[s]  <= {DATA_RANGES{rmp_pkg::PERM_RST}};
          store_en[s] <= {DATA_RANGES{rmp_pkg::PERM_RST}};
          fetch_en[s] <= {CODE_RANGES{rmp_pkg::PERM_RST}};
        end else begin
          // Bit x of the written word enables range x of this set.
          if (wr_load && hit_s) begin
            load_en[s] <= perm_wdata[DATA_RANGES-1:0];
          end
          if (wr_store && hit_s) begin
            store_en[s] <= perm_wdata[DATA_RANGES-1:0];
          end
          if (wr_fetch && hit_s) begin
            fetch_en[s] <= perm_wdata[CODE_RANGES-1:0];
          end
        end
      end
    end
  endgenerate

  wire logic [15:0] rd_load_w;
  wire logic [15:0] rd_store_w;
  wire logic [15:0] rd_fetch_w;
  assign rd_load_w  = 16'(load_en[perm_rd_set]);
  assign rd_store_w = 16'(store_en[perm_rd_set]);
  assign rd_fetch_w = 16'(fetch_en[perm_rd_set]);
  assign perm_rdata = (32'(perm_rd_set) >= SETS) ? 16'h0000 :
                      (perm_rd_kind == rmp_pkg::RMP_ACC_LOAD)  ? rd_load_w  :
                      (perm_rd_kind == rmp_pkg::RMP_ACC_STORE) ? rd_store_w :
                      (perm_rd_kind == rmp_pkg::RMP_ACC_FETCH) ? rd_fetch_w : 16'h0000;

  // ****************************************************************
  // Range matching against the active set
  // ****************************************************************
  // An out-of-range set number selects no permission at all, so the
  // field can never open memory by pointing at a missing set.
  wire logic                   set_ok;
  wire logic [DATA_RANGES-1:0] act_load;
  wire logic [DATA_RANGES-1:0] act_store;
  wire logic [CODE_RANGES-1:0] act_fetch;
  assign set_ok    = 32'(active_set_field) < SETS;
  assign act_load  = set_ok ? load_en[active_set_field]  : '0;
  assign act_store = set_ok ? store_en[active_set_field] : '0;
  assign act_fetch = set_ok ? fetch_en[active_set_field] : '0;

  logic grant_load;
  logic grant_store;
  logic grant_fetch;

  // Data ranges judge loads and stores, code ranges judge fetches.
  rmp_range_match #(.RANGES(DATA_RANGES)) u_load (
    .addr   (req_addr),
    .lower  (data_lo),
    .upper  (data_hi),
    .permit (act_load),
    .grant  (grant_load)
  );
  rmp_range_match #(.RANGES(DATA_RANGES)) u_store (
    .addr   (req_addr),
    .lower  (data_lo),
    .upper  (data_hi),
    .permit (act_store),
    .grant  (grant_store)
  );
  rmp_range_match #(.RANGES(CODE_RANGES)) u_fetch (
    .addr   (req_addr),
    .lower  (code_lo),
    .upper  (code_hi),
    .permit (act_fetch),
    .grant  (grant_fetch)
  );

  // ****************************************************************
  // Verdict
  // ****************************************************************
  wire logic is_load;
  wire logic is_store;
  wire logic is_fetch;
  wire logic kind_grant;
  wire logic checked;
  wire logic allow;
  assign is_load    = req_kind == rmp_pkg::RMP_ACC_LOAD;
  assign is_store   = req_kind == rmp_pkg::RMP_ACC_STORE;
  assign is_fetch   = req_kind == rmp_pkg::RMP_ACC_FETCH;
  assign kind_grant = (is_load && grant_load) || (is_store && grant_store) ||
                      (is_fetch && grant_fetch);
  // Paged accesses are judged elsewhere and pass straight through.
  assign checked    = guard_enable_bit && !req_paged;
  assign allow      = !checked || kind_grant;
  // Only the first byte of an access is judged, so a wide access that
  // starts just below an upper boundary may touch bytes beyond it.
  // Software should keep a small guard gap between ranges.

  // ****************************************************************
  // Next values of the registered outputs
  // ****************************************************************
  // A denied access still refreshes the forwarded kind and address;
  // without mem_valid the memory side never acts on them.
  wire logic          denied;
  wire logic          next_mem_valid;
  wire logic [1:0]    next_mem_kind;
  wire logic [AW-1:0] next_mem_addr;
  wire logic          next_store_trap;
  wire logic          next_load_trap;
  wire logic          next_fetch_trap;
  assign denied          = req_valid && !allow;
  assign next_mem_valid  = req_valid && allow;
  assign next_mem_kind   = req_valid ? req_kind : mem_kind;
  assign next_mem_addr   = req_valid ? req_addr : mem_addr;
  assign next_store_trap = denied && is_store;
  assign next_load_trap  = denied && is_load;
  assign next_fetch_trap = denied && is_fetch;

  always_ff @(posedge clock) begin
    if (srst) begin
      mem_valid <= 1'b0;
    end else begin
      mem_valid <= next_mem_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mem_kind <= rmp_pkg::RMP_ACC_LOAD;
      mem_addr <= '0;
    end else begin
      mem_kind <= next_mem_kind;
      mem_addr <= next_mem_addr;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      store_violation_trap <= 1'b0;
      load_violation_trap  <= 1'b0;
      fetch_violation_trap <= 1'b0;
    end else begin
      store_violation_trap <= next_store_trap;
      load_violation_trap  <= next_load_trap;
      fetch_violation_trap <= next_fetch_trap;
    end
  end

endmodule

// ---- verif/rmp_core_model.sv ----
`timescale 1ns/1ns
module rmp_core_model (
  // Clock
  input  wire logic                       clock,
  // Access request towards the checker
  output logic                            req_valid,
  output logic [1:0]                      req_kind,
  output logic [rmp_pkg::ADDR_W-1:0]      req_addr,
  output logic                            req_paged
);
  initial begin
    req_valid = 1'b0;
    req_kind  = 2'h0;
    req_addr  = 32'h0000_0000;
    req_paged = 1'b0;
  end

  // Released lines carry the inverse, so a stale request never passes for a live one.
  task automatic issue(input logic [1:0] kind, input logic [31:0] addr, input logic paged);
    @(posedge clock);
    #1;
    req_valid = 1'b1;
    req_kind  = kind;
    req_addr  = addr;
    req_paged = paged;
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    req_kind  = ~kind;
    req_addr  = ~addr;
    req_paged = ~paged;
  endtask
endmodule

// ---- verif/rmp_checker_properties.sv ----
`timescale 1ns/1ns
module rmp_checker_props #(
  parameter int unsigned CODE_RANGES = 16,
  parameter int unsigned DATA_RANGES = 16,
  parameter int unsigned SETS        = 4
) (
  // Clock, reset and control
  input wire logic        clock, srst, guard_enable_bit,
  // Request side
  input wire logic        req_valid, req_paged,
  input wire logic [1:0]  req_kind,
  input wire logic [31:0] req_addr,
  // Verdict side
  input wire logic        mem_valid, store_violation_trap,
  input wire logic        load_violation_trap, fetch_violation_trap,
  input wire logic [1:0]  mem_kind,
  input wire logic [31:0] mem_addr, bnd_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  wire [3:0] verdict = {mem_valid, store_violation_trap, load_violation_trap, fetch_violation_trap};

  property p_guard_off; req_valid && !guard_enable_bit && req_kind != 2'h3 |=> mem_valid; endproperty
  a_guard_off: assert property (p_guard_off) else $error("refused with protection off");
  property p_paged; req_valid && req_paged && req_kind != 2'h3 |=> mem_valid; endproperty
  a_paged: assert property (p_paged) else $error("paged access was judged");
  property p_one_verdict; req_valid && req_kind != 2'h3 |=> $onehot(verdict); endproperty
  a_one_verdict: assert property (p_one_verdict) else $error("not exactly one verdict");
  property p_store_trap; store_violation_trap |-> $past(req_valid) && $past(req_kind) == 2'h1;
  endproperty
  a_store_trap: assert property (p_store_trap) else $error("store trap without store");
  property p_load_trap; load_violation_trap |-> $past(req_valid) && $past(req_kind) == 2'h0;
  endproperty
  a_load_trap: assert property (p_load_trap) else $error("load trap without load");
  property p_fetch_trap; fetch_violation_trap |-> $past(req_valid) && $past(req_kind) == 2'h2;
  endproperty
  a_fetch_trap: assert property (p_fetch_trap) else $error("fetch trap without fetch");
  property p_idle; !req_valid |=> verdict == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("verdict without request");
  property p_copy; req_valid |=> mem_addr == $past(req_addr) && mem_kind == $past(req_kind);
  endproperty
  a_copy: assert property (p_copy) else $error("forwarded access differs");
  property p_hold; !req_valid |=> $stable(mem_addr) && $stable(mem_kind); endproperty
  a_hold: assert property (p_hold) else $error("forwarded access moved");
  property p_bnd_low; bnd_rdata[2:0] == 3'h0; endproperty
  a_bnd_low: assert property (p_bnd_low) else $error("boundary low bits not zero");

  c_store_trap: cover property (store_violation_trap);
  c_load_trap: cover property (load_violation_trap);
  c_fetch_ok: cover property (mem_valid && mem_kind == 2'h2);
endmodule

bind rmp_checker rmp_checker_props #(
  .CODE_RANGES(CODE_RANGES), .DATA_RANGES(DATA_RANGES), .SETS(SETS)
) u_props (
  .clock(clock), .srst(srst), .guard_enable_bit(guard_enable_bit),
  .req_valid(req_valid), .req_paged(req_paged), .req_kind(req_kind), .req_addr(req_addr),
  .mem_valid(mem_valid), .store_violation_trap(store_violation_trap),
  .load_violation_trap(load_violation_trap), .fetch_violation_trap(fetch_violation_trap),
  .mem_kind(mem_kind), .mem_addr(mem_addr), .bnd_rdata(bnd_rdata)
);

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic clock = 1'b0, srst = 1'b1, guard_enable_bit = 1'b1, bnd_wr = 1'b0, perm_wr = 1'b0;
  logic bnd_code = 1'b0, bnd_upper = 1'b0, bnd_rd_code = 1'b0, bnd_rd_upper = 1'b0;
  logic [1:0] active_set_field = 2'h0, perm_kind = 2'h0, perm_set = 2'h0;
  logic [1:0] perm_rd_kind = 2'h0, perm_rd_set = 2'h0;
  logic [3:0] bnd_idx = 4'h0, bnd_rd_idx = 4'h0;
  logic [31:0] bnd_wdata = 32'h0, bnd_rdata, req_addr, mem_addr;
  logic [15:0] perm_wdata = 16'h0, perm_rdata;
  logic req_valid, req_paged, mem_valid, st_trap, ld_trap, fe_trap;
  logic [1:0] req_kind, mem_kind;
  int fail_count = 0;
  int samples_checked = 0;

  always #4 clock = ~clock;

  rmp_core_model u_core (.clock(clock), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .req_paged(req_paged));

  rmp_checker DUT (.clock(clock), .srst(srst), .guard_enable_bit(guard_enable_bit),
    .active_set_field(active_set_field), .bnd_wr(bnd_wr), .bnd_code(bnd_code),
    .bnd_upper(bnd_upper), .bnd_idx(bnd_idx), .bnd_wdata(bnd_wdata),
    .bnd_rd_code(bnd_rd_code), .bnd_rd_upper(bnd_rd_upper), .bnd_rd_idx(bnd_rd_idx),
    .bnd_rdata(bnd_rdata), .perm_wr(perm_wr), .perm_kind(perm_kind), .perm_set(perm_set),
    .perm_wdata(perm_wdata), .perm_rd_kind(perm_rd_kind), .perm_rd_set(perm_rd_set),
    .perm_rdata(perm_rdata), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .req_paged(req_paged), .mem_valid(mem_valid), .mem_kind(mem_kind),
    .mem_addr(mem_addr), .store_violation_trap(st_trap), .load_violation_trap(ld_trap),
    .fetch_violation_trap(fe_trap));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic code, input logic upper, input logic [3:0] idx,
                    input logic [31:0] d);
    @(posedge clock);
    #1;
    {bnd_wr, bnd_code, bnd_upper, bnd_idx, bnd_wdata} = {1'b1, code, upper, idx, d};
    @(posedge clock);
    #1;
    bnd_wr = 1'b0;
  endtask

  task automatic wp(input logic [1:0] kind, input logic [1:0] set, input logic [15:0] d);
    @(posedge clock);
    #1;
    {perm_wr, perm_kind, perm_set, perm_wdata} = {1'b1, kind, set, d};
    @(posedge clock);
    #1;
    perm_wr = 1'b0;
  endtask

  // Read ports are combinational, so a short settle suffices.
  // Bit 4 of the selector picks the permission port for the compare.
  task automatic rd(input logic [4:0] sel, input logic [3:0] idx, input logic [31:0] exp);
    {bnd_rd_code, bnd_rd_upper, perm_rd_kind} = sel[3:0];
    {perm_rd_set, bnd_rd_idx} = {idx[1:0], idx};
    #1;
    chk(sel[4] ? {16'h0, perm_rdata} : bnd_rdata, exp);
  endtask

  // Kind three is judged but has no trap of its own.
  task automatic acc(input logic [1:0] k, input logic [31:0] a, input logic ok);
    logic [3:0] exp_v;
    exp_v = ok ? 4'h8 : (k == 2'h1) ? 4'h4 : (k == 2'h0) ? 4'h2 : (k == 2'h2) ? 4'h1 : 4'h0;
    u_core.issue(k, a, 1'b0);
    chk({28'h0, mem_valid, st_trap, ld_trap, fe_trap}, {28'h0, exp_v});
    chk(mem_addr, a);
    chk({30'h0, mem_kind}, {30'h0, k});
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clock);
    #1 srst = 1'b0;
    for (int k = 0; k < 3; k++) acc(k[1:0], 32'h0000_1000, 1'b0);
    u_core.issue(2'h1, 32'h0000_1000, 1'b1);
    chk({31'h0, mem_valid}, 32'h1);
    guard_enable_bit = 1'b0;
    for (int k = 0; k < 3; k++) acc(k[1:0], 32'h0000_1000, 1'b1);
    guard_enable_bit = 1'b1;
    wb(1'b0, 1'b0, 4'h2, 32'h0000_1005);
    wb(1'b0, 1'b1, 4'h2, 32'h0000_2007);
    wb(1'b0, 1'b1, 4'h3, 32'h0000_8000);
    rd(5'h00, 4'h2, 32'h0000_1000);
    rd(5'h04, 4'h2, 32'h0000_2000);
    wp(2'h0, 2'h1, 16'h0004);
    wp(2'h1, 2'h1, 16'h0008);
    wp(2'h3, 2'h1, 16'hffff);
    rd(5'h10, 4'h1, 32'h0000_0004);
    rd(5'h11, 4'h1, 32'h0000_0008);
    acc(2'h0, 32'h0000_1000, 1'b0);
    active_set_field = 2'h1;
    acc(2'h0, 32'h0000_0ffc, 1'b0);
    acc(2'h0, 32'h0000_1000, 1'b1);
    acc(2'h1, 32'h0000_1000, 1'b1);
    acc(2'h0, 32'h0000_1ffc, 1'b1);
    acc(2'h0, 32'h0000_2000, 1'b0);
    acc(2'h0, 32'h0000_4000, 1'b0);
    acc(2'h1, 32'h0000_4000, 1'b1);
    acc(2'h1, 32'h0000_9000, 1'b0);
    acc(2'h3, 32'h0000_1000, 1'b0);
    acc(2'h2, 32'h0000_1000, 1'b0);
    wb(1'b1, 1'b0, 4'h0, 32'h0000_1000);
    wb(1'b1, 1'b1, 4'h0, 32'h0000_1800);
    rd(5'h08, 4'h0, 32'h0000_1000);
    rd(5'h0c, 4'h0, 32'h0000_1800);
    wp(2'h2, 2'h1, 16'h0001);
    rd(5'h12, 4'h1, 32'h0000_0001);
    acc(2'h2, 32'h0000_1000, 1'b1);
    active_set_field = 2'h2;
    acc(2'h2, 32'h0000_1000, 1'b0);
    rd(5'h12, 4'h2, 32'h0000_0000);
    // A reset in mid-run must clear boundaries and permissions again.
    @(posedge clock);
    #1 srst = 1'b1;
    repeat (2) @(posedge clock);
    #1 srst = 1'b0;
    rd(5'h00, 4'h2, 32'h0000_0000);
    rd(5'h12, 4'h1, 32'h0000_0000);
    active_set_field = 2'h1;
    acc(2'h2, 32'h0000_1000, 1'b0);
    tally_and_finish();
  end
endmodule
